// >>> hw/rstsys_pkg.sv
// Package: register map, field positions and reset values of the reset/system block
package rstsys_pkg;

  // ---------------------------------------------------------------
  // Register indices on the CPU register port
  // ---------------------------------------------------------------
  typedef logic [1:0] reg_index_t;
  localparam reg_index_t REG_RESET_CAUSE_STATUS = 2'h0;
  localparam reg_index_t REG_DEBUG_FORCE_RESET = 2'h1;
  localparam reg_index_t REG_SYSTEM_OPTIONS_ONE = 2'h2;

  // ---------------------------------------------------------------
  // Status field positions and values
  // ---------------------------------------------------------------
  localparam int BIT_POWER_ON_FLAG = 7;
  localparam int BIT_PIN_FLAG = 6;
  localparam int BIT_WATCHDOG_FLAG = 5;
  localparam int BIT_ILLEGAL_OPCODE_FLAG = 4;
  localparam int BIT_CLOCK_GENERATOR_FLAG = 2;
  localparam int BIT_LOW_VOLTAGE_FLAG = 1;
  localparam logic [7:0] STATUS_POWER_ON_VALUE = 8'h82;
  localparam logic [7:0] STATUS_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Options field positions and values
  // ---------------------------------------------------------------
  localparam int BIT_WATCHDOG_ENABLE = 7;
  localparam int BIT_STOP_ALLOW = 5;
  localparam int BIT_FORCE_RESET = 0;
  localparam int BIT_RESET_PIN_ENABLE = 0;
  localparam logic [7:0] OPTIONS_RESET_VALUE = 8'hC2;
  localparam logic [7:0] OPTIONS_IMPL_MASK = 8'hF3;

  // ---------------------------------------------------------------
  // Reset stretch length
  // ---------------------------------------------------------------
  localparam int RESET_HOLD_CYCLES = 16;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } seq_state_e;

  // Reset requests seen in one cycle
  typedef struct packed {
    logic pin;
    logic watchdog;
    logic illegal_opcode;
    logic clock_generator;
    logic low_voltage;
    logic force_reset;
  } reset_src_s;

endpackage

// >>> hw/reset_status_and_system_options.sv
// Reset cause bookkeeping, debug force reset and write-once system options
`timescale 1ns/1ps
`default_nettype none

module reset_status_and_system_options
  import rstsys_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // CPU register port
  input wire reg_index_t cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_bdm_i,
  output logic [7:0] cpu_rdata_o,
  // Asynchronous pins
  input wire logic ext_reset_pin_n_i,
  input wire logic low_voltage_i,
  // Low-voltage controls
  input wire logic low_voltage_detect_enable_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic low_voltage_stop_enable_i,
  input wire logic in_stop_i,
  // Reset requests from the core and clock module
  input wire logic watchdog_timeout_i,
  input wire logic clock_generator_req_i,
  input wire logic illegal_opcode_i,
  input wire logic stop_instr_i,
  input wire logic bgnd_instr_i,
  input wire logic background_mode_allow_i,
  // Results
  output logic sys_reset_o,
  output logic watchdog_restart_o,
  output logic stop_granted_o,
  output logic [7:0] system_options_o
);

  localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYCLES - 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic lv_meta_ff;
  logic lv_sync_ff;
  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] reset_cause_status_ff;
  logic [7:0] nxt_status;
  logic [7:0] system_options_one_ff;
  logic [7:0] nxt_options;
  logic written_ff;
  logic force_reset_bit_ff;
  logic watchdog_restart_ff;
  logic [7:0] rdata_ff;
  reset_src_s src;
  logic any_src;
  logic in_run;
  logic bus_wr;
  logic wr_status;
  logic wr_force;
  logic wr_options;
  logic watchdog_enable;
  logic stop_allow;
  logic reset_pin_enable;
  logic lv_detect_on;
  logic [7:0] read_mux;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Idle levels at reset: no false request right after release
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      lv_meta_ff <= 1'b0;
      lv_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= ext_reset_pin_n_i;
      pin_sync_ff <= pin_meta_ff;
      lv_meta_ff <= low_voltage_i;
      lv_sync_ff <= lv_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Reset source qualification
  // ---------------------------------------------------------------
  // Pin counts only while the reset pin function is enabled
  assign watchdog_enable = system_options_one_ff[BIT_WATCHDOG_ENABLE];
  assign stop_allow = system_options_one_ff[BIT_STOP_ALLOW];
  assign reset_pin_enable = system_options_one_ff[BIT_RESET_PIN_ENABLE];
  assign lv_detect_on = low_voltage_detect_enable_i
                        & (~in_stop_i | low_voltage_stop_enable_i);
  assign src.pin = ~pin_sync_ff & reset_pin_enable;
  assign src.watchdog = watchdog_timeout_i & watchdog_enable;
  assign src.illegal_opcode = illegal_opcode_i
                              | (stop_instr_i & ~stop_allow)
                              | (bgnd_instr_i & ~background_mode_allow_i);
  assign src.clock_generator = clock_generator_req_i;
  assign src.low_voltage = lv_sync_ff & lv_detect_on & low_voltage_reset_enable_i;
  assign src.force_reset = force_reset_bit_ff;
  assign any_src = |src;
  assign stop_granted_o = stop_instr_i & stop_allow;

  // ---------------------------------------------------------------
  // Cause capture: active sources set, inactive cleared
  // ---------------------------------------------------------------
  // Power-on flag survives only a low-voltage reset
  always_comb begin
    nxt_status = STATUS_ZERO;
    nxt_status[BIT_POWER_ON_FLAG] = src.low_voltage
                                    & reset_cause_status_ff[BIT_POWER_ON_FLAG];
    nxt_status[BIT_PIN_FLAG] = src.pin;
    nxt_status[BIT_WATCHDOG_FLAG] = src.watchdog;
    nxt_status[BIT_ILLEGAL_OPCODE_FLAG] = src.illegal_opcode;
    nxt_status[BIT_CLOCK_GENERATOR_FLAG] = src.clock_generator;
    nxt_status[BIT_LOW_VOLTAGE_FLAG] = src.low_voltage;
  end

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  assign in_run = (state_ff == ST_RUN);

  // Any source during the stretch restarts the count
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (any_src) begin
          nxt_state = ST_HOLD;
          nxt_cnt = HOLD_LOAD;
        end
      end
      ST_HOLD: begin
        if (any_src) begin
          nxt_cnt = HOLD_LOAD;
        end else if (cnt_ff == 8'h00) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = ST_HOLD;
        nxt_cnt = HOLD_LOAD;
      end
    endcase
  end

  // State, counter and cause flags
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_HOLD;
      cnt_ff <= HOLD_LOAD;
      reset_cause_status_ff <= STATUS_POWER_ON_VALUE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (in_run && any_src) begin
        reset_cause_status_ff <= nxt_status;
      end
    end
  end

  assign sys_reset_o = ~in_run;

  // ---------------------------------------------------------------
  // Register writes, ignored while the system is in reset
  // ---------------------------------------------------------------
  // Lock reopens only after a reset, so the first write in run wins
  assign bus_wr = cpu_wr_i & in_run;
  assign wr_status = bus_wr & (cpu_addr_i == REG_RESET_CAUSE_STATUS);
  assign wr_force = bus_wr & (cpu_addr_i == REG_DEBUG_FORCE_RESET) & cpu_bdm_i;
  assign wr_options = bus_wr & (cpu_addr_i == REG_SYSTEM_OPTIONS_ONE) & ~written_ff;

  // Write-once options; reset pin enable only cleared by power-on
  always_comb begin
    nxt_options = system_options_one_ff;
    if (!in_run) begin
      nxt_options = OPTIONS_RESET_VALUE;
      nxt_options[BIT_RESET_PIN_ENABLE] = reset_pin_enable;
    end else if (wr_options) begin
      nxt_options = cpu_wdata_i & OPTIONS_IMPL_MASK;
      nxt_options[BIT_RESET_PIN_ENABLE] = reset_pin_enable
                                          | cpu_wdata_i[BIT_RESET_PIN_ENABLE];
    end
  end

  // Options, lock, force pulse and watchdog restart
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      system_options_one_ff <= OPTIONS_RESET_VALUE & 8'hFE;
      written_ff <= 1'b0;
      force_reset_bit_ff <= 1'b0;
      watchdog_restart_ff <= 1'b0;
    end else begin
      system_options_one_ff <= nxt_options;
      written_ff <= in_run & (written_ff | wr_options);
      force_reset_bit_ff <= wr_force & cpu_wdata_i[BIT_FORCE_RESET];
      watchdog_restart_ff <= wr_status;
    end
  end

  assign watchdog_restart_o = watchdog_restart_ff;
  assign system_options_o = system_options_one_ff;

  // ---------------------------------------------------------------
  // Read path, registered
  // ---------------------------------------------------------------
  // Force register and unmapped index read as zero
  assign read_mux = (cpu_addr_i == REG_RESET_CAUSE_STATUS) ? reset_cause_status_ff :
                    (cpu_addr_i == REG_SYSTEM_OPTIONS_ONE) ?
                    (system_options_one_ff & OPTIONS_IMPL_MASK) :
                    STATUS_ZERO;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= STATUS_ZERO;
    end else begin
      rdata_ff <= read_mux;
    end
  end

  assign cpu_rdata_o = rdata_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_por_flags_set: assert property ($past(!reset_n_i) |->
    reset_cause_status_ff == STATUS_POWER_ON_VALUE && sys_reset_o)
    else $error("power-on flags wrong");
  a_force_clears_all: assert property (in_run && src == reset_src_s'(6'h01) |=>
    reset_cause_status_ff == STATUS_ZERO) else $error("force reset left a flag");
  a_status_write_keeps: assert property (wr_status && !any_src |=>
    $stable(reset_cause_status_ff) && watchdog_restart_o)
    else $error("status write misbehaved");
  a_low_volt_capture: assert property (in_run && src.low_voltage |=>
    reset_cause_status_ff[BIT_POWER_ON_FLAG] == $past(reset_cause_status_ff[7])
    && reset_cause_status_ff[BIT_LOW_VOLTAGE_FLAG]) else $error("low-voltage capture wrong");
  a_pin_flag_set: assert property (in_run && src.pin |=>
    reset_cause_status_ff[BIT_PIN_FLAG] && sys_reset_o) else $error("pin flag missing");
  a_wdog_flag_gate: assert property (in_run && watchdog_timeout_i |=>
    reset_cause_status_ff[BIT_WATCHDOG_FLAG] == ($past(watchdog_enable)
    || ($past(!any_src) && $past(reset_cause_status_ff[BIT_WATCHDOG_FLAG]))))
    else $error("watchdog flag wrong");
  a_stop_illegal_reset: assert property (in_run && stop_instr_i && !stop_allow |=>
    reset_cause_status_ff[BIT_ILLEGAL_OPCODE_FLAG] && sys_reset_o)
    else $error("disallowed stop not reset");
  a_bgnd_illegal_reset: assert property (in_run && bgnd_instr_i && !background_mode_allow_i
    |=> reset_cause_status_ff[BIT_ILLEGAL_OPCODE_FLAG])
    else $error("disallowed background not reset");
  a_clkgen_flag_set: assert property (in_run && clock_generator_req_i |=>
    reset_cause_status_ff[BIT_CLOCK_GENERATOR_FLAG]) else $error("clock flag missing");
  a_lv_enable_gate: assert property (in_run && lv_sync_ff && !low_voltage_reset_enable_i
    && src == reset_src_s'(6'h00) |=> !sys_reset_o)
    else $error("low-voltage reset without enable");
  a_inactive_cleared: assert property (in_run && any_src && !src.pin |=>
    !reset_cause_status_ff[BIT_PIN_FLAG]) else $error("inactive flag kept");
  a_user_force_ignored: assert property (bus_wr && !cpu_bdm_i |=>
    !force_reset_bit_ff) else $error("user write forced reset");
  a_debug_force_reset: assert property (wr_force && cpu_wdata_i[0] |=> ##1
    sys_reset_o) else $error("debug force reset missing");
  a_force_reads_zero: assert property (cpu_addr_i == REG_DEBUG_FORCE_RESET |=>
    cpu_rdata_o == STATUS_ZERO) else $error("force register read not zero");
  a_opt_unimpl_zero: assert property (cpu_addr_i == REG_SYSTEM_OPTIONS_ONE |=>
    cpu_rdata_o[3:2] == 2'b00) else $error("options bits 3:2 not zero");
  a_opt_write_once: assert property (written_ff && in_run |=>
    $stable(system_options_one_ff) || sys_reset_o) else $error("second options write taken");
  a_opt_reset_vals: assert property (sys_reset_o |=>
    system_options_one_ff[BIT_WATCHDOG_ENABLE] && !system_options_one_ff[BIT_STOP_ALLOW])
    else $error("options reset values wrong");
  a_status_unimpl: assert property (reset_cause_status_ff[3] == 1'b0 &&
    reset_cause_status_ff[0] == 1'b0) else $error("status bits 3 or 0 set");

  // Gating, read path and lock checks
  a_wdog_blocked: assert property (!watchdog_enable |-> !src.watchdog)
    else $error("watchdog source not blocked");
  a_lv_stop_gate: assert property (in_stop_i && !low_voltage_stop_enable_i |->
    !src.low_voltage) else $error("low-voltage detect active in stop");
  a_bad_opcode_reset: assert property (in_run && illegal_opcode_i |=>
    reset_cause_status_ff[BIT_ILLEGAL_OPCODE_FLAG] && sys_reset_o)
    else $error("illegal opcode not reset");
  a_no_spurious_reset: assert property (in_run && !any_src |=>
    !sys_reset_o) else $error("reset without a source");
  a_status_kept_run: assert property (in_run && !any_src |=>
    $stable(reset_cause_status_ff)) else $error("status changed in run");
  a_restart_one_shot: assert property (!wr_status |=>
    !watchdog_restart_o) else $error("watchdog restart without write");
  a_status_read: assert property (cpu_addr_i == REG_RESET_CAUSE_STATUS |=>
    cpu_rdata_o == $past(reset_cause_status_ff)) else $error("status read wrong");
  a_opt_read: assert property (cpu_addr_i == REG_SYSTEM_OPTIONS_ONE |=>
    cpu_rdata_o == ($past(system_options_one_ff) & OPTIONS_IMPL_MASK))
    else $error("options read wrong");
  a_first_write_taken: assert property (wr_options |=>
    system_options_one_ff[7:4] == $past(cpu_wdata_i[7:4]) && written_ff)
    else $error("first options write lost");
  a_lock_cleared: assert property (sys_reset_o |=> !written_ff)
    else $error("options lock kept through reset");

  // Main scenarios
  c_watchdog_reset: cover property (in_run && src.watchdog);
  c_options_locked: cover property (wr_options ##1 written_ff);
  c_debug_forced: cover property (wr_force && cpu_wdata_i[0]);
  c_hold_release: cover property (sys_reset_o ##1 !sys_reset_o);
  c_low_voltage_reset: cover property (in_run && src.low_voltage);

endmodule

`default_nettype wire

// >>> testbench/reg_host.sv
// Debug host and user software model driving the register port
`timescale 1ns/1ps
`default_nettype none

module reg_host
  import rstsys_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output var reg_index_t cpu_addr_o,
  output logic cpu_wr_o,
  output logic [7:0] cpu_wdata_o,
  output logic cpu_bdm_o,
  input wire logic [7:0] cpu_rdata_i
);
  // Idle bus from time zero
  initial begin
    cpu_addr_o = REG_RESET_CAUSE_STATUS;
    cpu_wr_o = 1'b0;
    cpu_wdata_o = 8'h00;
    cpu_bdm_o = 1'b0;
  end

  // One-cycle write strobe, bdm marks a background debug command
  task automatic wr(input reg_index_t idx, input logic [7:0] d, input logic bdm);
    @(posedge clk_i);
    #1;
    cpu_addr_o = idx;
    cpu_wdata_o = d;
    cpu_bdm_o = bdm;
    cpu_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    cpu_wr_o = 1'b0;
    cpu_bdm_o = 1'b0;
    cpu_wdata_o = ~d; // Released data does not keep its value
  endtask

  // Read data answers one cycle after the index
  task automatic rd(input reg_index_t idx, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    cpu_addr_o = idx;
    @(posedge clk_i);
    #1;
    d = cpu_rdata_i;
  endtask
endmodule

`default_nettype wire

// >>> testbench/test_reset_status_and_system_options.sv
// Self-checking bench for reset bookkeeping and write-once options
`timescale 1ns/1ps
`default_nettype none

module test_reset_status_and_system_options
  import rstsys_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk_i, reset_n_i, cpu_wr_i, cpu_bdm_i, sys_reset_o, watchdog_restart_o, stop_granted_o;
  reg_index_t cpu_addr_i;
  logic [7:0] cpu_wdata_i, cpu_rdata_o, system_options_o, rd_val;
  logic ext_n, lv, lv_de, lv_re, lv_se, in_stop, wd, cg, bad_op, stop_ins, bgnd, bgnd_ok;
  int n_fail, n_checks;
  logic [6:0] src_tab [6] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h18};
  logic [7:0] exp_tab [6] = '{8'h20, 8'h04, 8'h10, 8'h10, 8'h10, 8'h24};

  reset_status_and_system_options #(.HOLD_CYCLES(2)) reset_status_and_system_options_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_bdm_i(cpu_bdm_i), .cpu_rdata_o(cpu_rdata_o),
    .ext_reset_pin_n_i(ext_n), .low_voltage_i(lv), .low_voltage_detect_enable_i(lv_de),
    .low_voltage_reset_enable_i(lv_re), .low_voltage_stop_enable_i(lv_se),
    .in_stop_i(in_stop), .watchdog_timeout_i(wd), .clock_generator_req_i(cg),
    .illegal_opcode_i(bad_op), .stop_instr_i(stop_ins), .bgnd_instr_i(bgnd),
    .background_mode_allow_i(bgnd_ok), .sys_reset_o(sys_reset_o),
    .watchdog_restart_o(watchdog_restart_o), .stop_granted_o(stop_granted_o),
    .system_options_o(system_options_o)
  );

  reg_host reg_host_i (
    .clk_i(clk_i), .cpu_addr_o(cpu_addr_i), .cpu_wr_o(cpu_wr_i),
    .cpu_wdata_o(cpu_wdata_i), .cpu_bdm_o(cpu_bdm_i), .cpu_rdata_i(cpu_rdata_o)
  );

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Checking and stimulus tasks
  // ---------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic rd_chk(input reg_index_t idx, input logic [7:0] exp);
    reg_host_i.rd(idx, rd_val);
    chk_byte(rd_val, exp);
  endtask

  // Source vector: lv, pin, watchdog, clock gen, illegal op, stop, background
  task automatic set_src(input logic [6:0] s);
    @(posedge clk_i);
    #1;
    {lv, ext_n, wd, cg, bad_op, stop_ins, bgnd} = {s[6], ~s[5], s[4:0]};
  endtask

  // Bounded wait for the system reset level
  task automatic wait_rst(input logic lvl);
    for (int i = 0; i < 50 && sys_reset_o !== lvl; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk_bit(sys_reset_o, lvl);
  endtask

  // Raise sources, let the stretched reset finish, then read the causes
  task automatic src_reset(input logic [6:0] s, input logic [7:0] exp);
    set_src(s);
    wait_rst(1'b1);
    set_src(7'h00);
    wait_rst(1'b0);
    rd_chk(REG_RESET_CAUSE_STATUS, exp);
  endtask

  // Sources that must not reset the device
  task automatic no_reset(input logic [6:0] s);
    logic seen;
    seen = 1'b0;
    set_src(s);
    repeat (6) begin
      @(posedge clk_i);
      #1;
      seen = seen | sys_reset_o;
    end
    set_src(7'h00);
    chk_bit(seen, 1'b0);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    reset_n_i = 1'b0;
    {lv_de, lv_re, lv_se, in_stop, bgnd_ok} = 5'b00000;
    {lv, ext_n, wd, cg, bad_op, stop_ins, bgnd} = 7'b0100000;
    repeat (5) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    wait_rst(1'b0);
    rd_chk(REG_RESET_CAUSE_STATUS, STATUS_POWER_ON_VALUE);
    rd_chk(REG_SYSTEM_OPTIONS_ONE, 8'hC2);
    rd_chk(REG_DEBUG_FORCE_RESET, 8'h00);
    rd_chk(2'h3, 8'h00);
    no_reset(7'h40);
    lv_re = 1'b1;
    no_reset(7'h40);
    lv_de = 1'b1;
    in_stop = 1'b1;
    no_reset(7'h40);
    lv_se = 1'b1;
    src_reset(7'h40, 8'h82);
    reg_host_i.wr(REG_RESET_CAUSE_STATUS, 8'hFF, 1'b0);
    chk_bit(watchdog_restart_o, 1'b1);
    @(posedge clk_i);
    #1;
    chk_bit(watchdog_restart_o, 1'b0);
    rd_chk(REG_RESET_CAUSE_STATUS, 8'h82);
    reg_host_i.wr(REG_DEBUG_FORCE_RESET, 8'h01, 1'b0);
    no_reset(7'h00);
    reg_host_i.wr(REG_SYSTEM_OPTIONS_ONE, 8'hF7, 1'b0);
    chk_byte(system_options_o, 8'hF3);
    stop_ins = 1'b1;
    #1;
    chk_bit(stop_granted_o, 1'b1);
    set_src(7'h00);
    reg_host_i.wr(REG_SYSTEM_OPTIONS_ONE, 8'h00, 1'b0);
    rd_chk(REG_SYSTEM_OPTIONS_ONE, 8'hF3);
    reg_host_i.wr(REG_DEBUG_FORCE_RESET, 8'h01, 1'b1);
    src_reset(7'h00, STATUS_ZERO);
    reg_host_i.wr(REG_SYSTEM_OPTIONS_ONE, 8'h5F, 1'b0);
    chk_byte(system_options_o, 8'h53);
    no_reset(7'h10);
    src_reset(7'h20, 8'h40);
    for (int k = 0; k < 6; k++) begin
      src_reset(src_tab[k], exp_tab[k]);
    end
    report_and_stop();
  end

  // Watchdog on a hung run
  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end
endmodule

`default_nettype wire
